// file: hdl/idr_map.vh
// constants for the interrupt delivery router
`ifndef IDR_MAP_VH
`define IDR_MAP_VH
`define IDR_OFF_CTRL        4'h0
`define IDR_OFF_NODE_LIST   4'h1
`define IDR_OFF_DECODE_IDX  4'h2
`define IDR_OFF_DECODE_DATA 4'h3
`define IDR_OFF_LOCAL_CFG   4'h4
`define IDR_OFF_STATUS      4'h5
`define IDR_OFF_ERR_COUNT   4'h6
`define IDR_CTRL_RR_MODE    0
`define IDR_CTRL_EXT_RDIS   2
`define IDR_CTRL_VSEL_LO    3
`define IDR_CTRL_VSEL_HI    4
`define IDR_CTRL_PHYS_BCAST 6
`define IDR_CTRL_RESET      8'h00
`define IDR_MODE_LEG_PHYS   2'h0
`define IDR_MODE_EXT_PHYS   2'h1
`define IDR_MODE_EXT_CLUS   2'h2
`define IDR_MODE_FLAT_LOG   2'h3
`define IDR_LEG_BCAST_ID    8'hFF
`define IDR_EXT_BCAST_ID    32'hFFFFFFFF
`define IDR_CLUS_BCAST_ID   16'hFFFF
`endif

// file: hdl/idr_decode_mem.v
// node decode table memory, registered read
`timescale 1ns/1ps
module idr_decode_mem #(
	parameter AW = 4,
	parameter DW = 6
) (
	input  wire          clk_in,
	input  wire          ce_in,
	input  wire          we_in,
	input  wire [AW-1:0] waddr_in,
	input  wire [DW-1:0] wdata_in,
	input  wire [AW-1:0] raddr_in,
	output reg  [DW-1:0] rdata_out
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	// no reset on the array or the read register; the read register loads on every enabled cycle
	always @(posedge clk_in) begin
		if (ce_in) begin
			if (we_in) begin
				mem[waddr_in] <= wdata_in;
			end
			rdata_out <= mem[raddr_in];
		end
	end
endmodule // idr_decode_mem

// file: hdl/idr_pick8.v
// eight-way target picker: vector search or round-robin from a start point
`timescale 1ns/1ps
module idr_pick8 (
	input  wire [7:0] mask_in,
	input  wire [2:0] start_in,
	input  wire       rr_in,
	output reg  [2:0] sel_out,
	output reg        found_out
);
	// vector order: +0,+4,+2,+6,+3,+7,+1,+5 ; round-robin order: +0..+7
	function [2:0] step;
		input       rr;
		input [2:0] k;
		begin
			case (k)
				3'h0: step = 3'h0;
				3'h1: step = rr ? 3'h1 : 3'h4;
				3'h2: step = 3'h2;
				3'h3: step = rr ? 3'h3 : 3'h6;
				3'h4: step = rr ? 3'h4 : 3'h3;
				3'h5: step = rr ? 3'h5 : 3'h7;
				3'h6: step = rr ? 3'h6 : 3'h1;
				default: step = 3'h5 + {2'h0, rr} + {2'h0, rr};
			endcase
		end
	endfunction
	integer i;
	reg [2:0] cand;
	always @* begin
		sel_out = 3'h0;
		found_out = 1'b0;
		cand = 3'h0;
		for (i = 7; i >= 0; i = i - 1) begin
			cand = start_in + step(rr_in, i[2:0]);
			if (mask_in[cand]) begin
				sel_out = cand;
				found_out = 1'b1;
			end
		end
	end
endmodule // idr_pick8

// file: hdl/idr_router.v
// interrupt delivery router: classification, node lookup, redirection, fan-out
//
// Summary of operation
// R01 - legacy physical target low byte all ones is a broadcast
// R02 - extended physical target all 32 bits ones is a broadcast
// R03 - extended cluster number bits 31:16 all ones is a broadcast
// R04 - non-broadcast goes to owning node; control bit 6 forces broadcast
// R05 - physical interrupts never redirected; hint passed through unchanged
// R06 - forced physical broadcast clears hint for legacy mode
// R07 - extended cluster redirected by vector or round-robin among eight
// R08 - after cluster redirection clear hint, keep only chosen mask bit
// R09 - control bit 2 disables extended cluster redirection
// R10 - with redirection disabled forward cluster interrupt unmodified
// R11 - non-broadcast local destination node from the node decode table
// R12 - sources give only valid enabled targets; no check is made
// R13 - local targets go to local processor, remote to node controller
// R14 - physical broadcast sends a physical message to every processor node
// R15 - redirected flat logical picks one of eight, sends to all nodes
// R16 - broadcast physical or cluster with hint set is an error, dropped
// R17 - round-robin starts at lowest enabled bit, moves upward
// R18 - flat vector start from bits 6:4, or 5:3, 3:1, 2:0 by field
// R19 - one round-robin state per cluster, up to fifteen clusters
// R20 - broadcast issues one message per configured node in fixed order
`timescale 1ns/1ps
`include "idr_map.vh"
module idr_router #(
	parameter NODES   = 8,
	parameter NODE_W  = 6,
	parameter CLUSTERS = 15
) (
	input  wire              clk_in,
	input  wire              rst_in,
	input  wire              ce_in,
	input  wire [3:0]        reg_addr_in,
	input  wire [31:0]       reg_wdata_in,
	input  wire              reg_wr_in,
	input  wire              reg_rd_in,
	output reg  [31:0]       reg_rdata_out,
	input  wire              irq_valid_in,
	output wire              irq_ready_out,
	input  wire [1:0]        irq_mode_in,
	input  wire [31:0]       irq_target_in,
	input  wire [7:0]        irq_vector_in,
	input  wire              irq_hint_in,
	input  wire              irq_redirect_in,
	output reg               msg_valid_out,
	input  wire              msg_ready_in,
	output reg               msg_logical_out,
	output reg  [NODE_W-1:0] msg_node_out,
	output reg  [31:0]       msg_target_out,
	output reg  [7:0]        msg_vector_out,
	output reg               msg_hint_out,
	output reg               err_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_LOOK = 2'h1;
	localparam ST_SEND = 2'h2;
	localparam ST_BCST = 2'h3;
	localparam RR_W    = 3 * (CLUSTERS + 1);

	reg [7:0]            ctrl;
	reg [NODES-1:0]      node_en;
	reg [3:0]            dec_idx;
	reg [4:0]            local_mask;
	reg [4:0]            local_val;
	reg [NODE_W-1:0]     nc_node;
	reg [7:0]            err_count;
	reg [1:0]            state;
	reg [2:0]            bc_idx;
	reg [1:0]            h_mode;
	reg [31:0]           h_target;
	reg [7:0]            h_vector;
	reg                  h_hint;
	wire [RR_W-1:0]      rr_flat;
	wire [NODE_W-1:0]    dec_rdata;
	wire [3:0]           dec_raddr;
	reg [31:0]           next_target;
	reg                  next_hint;
	reg [NODE_W-1:0]     next_node_num;

	wire rr_mode = ctrl[`IDR_CTRL_RR_MODE];
	wire ext_rdis = ctrl[`IDR_CTRL_EXT_RDIS];
	wire phys_bc = ctrl[`IDR_CTRL_PHYS_BCAST];
	wire [1:0] vsel = ctrl[`IDR_CTRL_VSEL_HI:`IDR_CTRL_VSEL_LO];

	// broadcast classification
	function is_bcast;
		input [1:0]  mode;
		input [31:0] tgt;
		begin
			case (mode)
				`IDR_MODE_LEG_PHYS: is_bcast = tgt[7:0] == `IDR_LEG_BCAST_ID;   // [R01]
				`IDR_MODE_EXT_PHYS: is_bcast = tgt == `IDR_EXT_BCAST_ID;        // [R02]
				`IDR_MODE_EXT_CLUS: is_bcast = tgt[31:16] == `IDR_CLUS_BCAST_ID; // [R03]
				default: is_bcast = 1'b0;
			endcase
		end
	endfunction

	// flat logical targets are a mask and never a broadcast
	wire in_bcast = is_bcast(irq_mode_in, irq_target_in);
	wire h_bcast = is_bcast(h_mode, h_target);
	wire h_phys = (h_mode == `IDR_MODE_LEG_PHYS) || (h_mode == `IDR_MODE_EXT_PHYS);
	wire h_clus = h_mode == `IDR_MODE_EXT_CLUS;
	wire h_flat = h_mode == `IDR_MODE_FLAT_LOG;

	// cluster number 0xFFFF is the broadcast; others fold onto the arbiters
	wire [3:0] clus_idx = (h_target[19:16] == 4'hF) ? 4'hE : h_target[19:16];
	wire [3:0] rr_slot = h_flat ? 4'hF : clus_idx; // [R19]
	wire [2:0] rr_start = rr_flat[3*rr_slot +: 3];

	reg [2:0] vec_start;
	always @* begin
		case (vsel)
			2'h0: vec_start = h_vector[6:4]; // [R18]
			2'h1: vec_start = h_vector[5:3];
			2'h2: vec_start = h_vector[3:1];
			default: vec_start = h_vector[2:0];
		endcase
	end

	wire [2:0] pick_sel;
	wire       pick_found;
	idr_pick8 u_pick (
		.mask_in   (h_target[7:0]),
		.start_in  (rr_mode ? rr_start : vec_start),
		.rr_in     (rr_mode),
		.sel_out   (pick_sel),
		.found_out (pick_found)
	);

	// table index: cluster number in cluster mode, low target bits otherwise
	function [3:0] table_index;
		input [1:0]  mode;
		input [31:0] tgt;
		begin
			if (mode == `IDR_MODE_EXT_CLUS) begin
				table_index = tgt[19:16];
			end else begin
				table_index = tgt[3:0];
			end
		end
	endfunction

	// the read register must hold the entry by the lookup state, so while idle
	// the table is addressed straight from the request that is about to be taken
	assign dec_raddr = (state == ST_IDLE) ? table_index(irq_mode_in, irq_target_in) :
		table_index(h_mode, h_target);

	wire dec_we = ce_in && reg_wr_in && (reg_addr_in == `IDR_OFF_DECODE_DATA);
	// entries are written through the index register
	idr_decode_mem #(.AW(4), .DW(NODE_W)) u_dec (
		.clk_in    (clk_in),
		.ce_in     (ce_in),
		.we_in     (dec_we),
		.waddr_in  (dec_idx),
		.wdata_in  (reg_wdata_in[NODE_W-1:0]),
		.raddr_in  (dec_raddr), // [R11]
		.rdata_out (dec_rdata)
	);

	// a single request is held at a time; the source stalls on ready
	assign irq_ready_out = (state == ST_IDLE) && !rst_in;

	wire irq_redirect_ok = !ext_rdis; // [R09]
	wire do_redir = (h_clus && h_hint && irq_redirect_ok) || (h_flat && h_hint);
	// control bit 6 turns routed physical and cluster traffic into a broadcast
	wire send_bcast = h_bcast || (h_phys && phys_bc) || (h_clus && phys_bc); // [R04]
	wire is_local = (h_target[8:4] & local_mask) == (local_val & local_mask);

	// next node in the configured list at or after a position
	function [3:0] next_node;
		input [NODES-1:0] en;
		input [2:0]       from;
		integer k;
		begin
			next_node = 4'h8;
			for (k = NODES - 1; k >= 0; k = k - 1) begin
				if (en[k] && (k >= from)) begin
					next_node = k[3:0];
				end
			end
		end
	endfunction

	wire [3:0] bc_first = next_node(node_en, 3'h0);
	wire [3:0] bc_after = (bc_idx == 3'h7) ? 4'h8 : next_node(node_en, bc_idx + 3'h1);

	// fabric node number for a position in the node list
	function [NODE_W-1:0] node_of;
		input [3:0] idx;
		begin
			node_of = {NODE_W{1'b0}};
			node_of[2:0] = idx[2:0];
		end
	endfunction

	// one pointer per cluster so a busy cluster does not skew another's rotation
	wire rr_step = (state == ST_LOOK) && do_redir && pick_found && rr_mode;
	genvar g;
	generate
		for (g = 0; g <= CLUSTERS; g = g + 1) begin : g_rr
			reg [2:0] ptr;
			always @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					ptr <= 3'h0; // [R17]
				end else if (ce_in && rr_step && (rr_slot == g)) begin
					ptr <= pick_sel + 3'h1; // [R17] [R19]
				end
			end
			assign rr_flat[3*g +: 3] = ptr;
		end
	endgenerate

	// message fields as they leave the lookup state
	always @* begin
		next_target = h_target;
		next_hint = h_hint; // [R05] [R10]
		next_node_num = is_local ? dec_rdata : nc_node; // [R11] [R13]
		if (do_redir) begin
			next_target = {h_target[31:8], 8'h01 << pick_sel}; // [R07] [R08] [R15]
			next_hint = 1'b0; // [R08]
		end
		if (phys_bc && (h_mode == `IDR_MODE_LEG_PHYS)) begin
			next_hint = 1'b0; // [R06]
		end
		if (send_bcast || h_flat) begin
			next_node_num = node_of(bc_first);
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl <= `IDR_CTRL_RESET;
			node_en <= {NODES{1'b0}};
			dec_idx <= 4'h0;
			local_mask <= 5'h00;
			local_val <= 5'h00;
			nc_node <= {NODE_W{1'b0}};
			err_count <= 8'h00;
			reg_rdata_out <= 32'h00000000;
			state <= ST_IDLE;
			bc_idx <= 3'h0;
			h_mode <= 2'h0;
			h_target <= 32'h00000000;
			h_vector <= 8'h00;
			h_hint <= 1'b0;
			msg_valid_out <= 1'b0;
			msg_logical_out <= 1'b0;
			msg_node_out <= {NODE_W{1'b0}};
			msg_target_out <= 32'h00000000;
			msg_vector_out <= 8'h00;
			msg_hint_out <= 1'b0;
			err_out <= 1'b0;
		end else if (ce_in) begin
			err_out <= 1'b0;
			if (reg_wr_in) begin
				case (reg_addr_in)
					`IDR_OFF_CTRL: ctrl <= reg_wdata_in[7:0];
					`IDR_OFF_NODE_LIST: node_en <= reg_wdata_in[NODES-1:0];
					`IDR_OFF_DECODE_IDX: dec_idx <= reg_wdata_in[3:0];
					`IDR_OFF_LOCAL_CFG: begin
						local_mask <= reg_wdata_in[4:0];
						local_val <= reg_wdata_in[12:8];
						nc_node <= reg_wdata_in[16+NODE_W-1:16];
					end
					default: ;
				endcase
			end
			if (reg_rd_in) begin
				case (reg_addr_in)
					`IDR_OFF_CTRL: reg_rdata_out <= {24'h000000, ctrl};
					`IDR_OFF_NODE_LIST: reg_rdata_out <= {{(32-NODES){1'b0}}, node_en};
					`IDR_OFF_DECODE_IDX: reg_rdata_out <= {28'h0000000, dec_idx};
					`IDR_OFF_LOCAL_CFG: reg_rdata_out <= {{(16-NODE_W){1'b0}}, nc_node,
						3'h0, local_val, 3'h0, local_mask};
					`IDR_OFF_STATUS: reg_rdata_out <= {27'h0000000, bc_idx, state};
					`IDR_OFF_ERR_COUNT: reg_rdata_out <= {24'h000000, err_count};
					default: reg_rdata_out <= 32'h00000000;
				endcase
			end
			case (state)
				ST_IDLE: begin
					if (irq_valid_in) begin
						h_mode <= irq_mode_in;
						h_target <= irq_target_in; // [R12]
						h_vector <= irq_vector_in;
						h_hint <= irq_hint_in;
						if (in_bcast && irq_hint_in &&
								irq_mode_in != `IDR_MODE_FLAT_LOG) begin
							err_out <= 1'b1; // [R16]
							err_count <= err_count + 8'h01;
						end else begin
							state <= ST_LOOK;
						end
					end
				end
				ST_LOOK: begin
					msg_logical_out <= !h_phys;
					msg_target_out <= next_target;
					msg_vector_out <= h_vector;
					msg_hint_out <= next_hint;
					msg_node_out <= next_node_num;
					if (do_redir && !pick_found) begin
						// no enabled target under the mask: drop it and count it
						err_out <= 1'b1;
						err_count <= err_count + 8'h01;
						state <= ST_IDLE;
					end else begin
						if (send_bcast || h_flat) begin
							if (bc_first[3]) begin
								state <= ST_IDLE; // empty node list: nothing to deliver
							end else begin
								bc_idx <= bc_first[2:0];
								msg_valid_out <= 1'b1;
								state <= ST_BCST; // [R14] [R15]
							end
						end else begin
							msg_valid_out <= 1'b1;
							state <= ST_SEND;
						end
					end
				end
				ST_SEND: begin
					if (msg_ready_in) begin
						msg_valid_out <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_BCST: begin
					if (msg_ready_in) begin
						if (bc_after[3]) begin
							msg_valid_out <= 1'b0;
							state <= ST_IDLE;
						end else begin
							bc_idx <= bc_after[2:0];
							msg_node_out <= node_of(bc_after); // [R20]
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // idr_router

// file: sim/idr_router_assertions.sv
// port assertions for the interrupt delivery router
`timescale 1ns/1ps
`include "idr_map.vh"
module idr_router_assertions (
	input wire        clk_in,
	input wire        rst_in,
	input wire        ce_in,
	input wire [3:0]  reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire        reg_wr_in,
	input wire        irq_valid_in,
	input wire        irq_ready_out,
	input wire [1:0]  irq_mode_in,
	input wire [31:0] irq_target_in,
	input wire        irq_hint_in,
	input wire        msg_valid_out,
	input wire        msg_ready_in,
	input wire        msg_logical_out,
	input wire [31:0] msg_target_out,
	input wire        msg_hint_out,
	input wire        err_out
);
	reg [1:0]  m_q;
	reg [31:0] t_q;
	reg        h_q;
	reg [7:0]  c_q;
	wire       mo = msg_valid_out;
	// last taken request and control, so every message has a known cause
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			m_q <= 2'h0;
			t_q <= 32'h0;
			h_q <= 1'b0;
			c_q <= 8'h00;
		end else begin
			if (irq_valid_in && irq_ready_out && ce_in) begin
				m_q <= irq_mode_in;
				t_q <= irq_target_in;
				h_q <= irq_hint_in;
			end
			if (reg_wr_in && ce_in && reg_addr_in == `IDR_OFF_CTRL)
				c_q <= reg_wdata_in[7:0];
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_take;
		irq_valid_in && irq_ready_out && ce_in;
	endsequence
	sequence s_drop;
		err_out ##1 !mo;
	endsequence
	a_hint_bcast_err: assert property (s_take ##0 (irq_mode_in == `IDR_MODE_LEG_PHYS &&
		irq_target_in[7:0] == 8'hFF && irq_hint_in) |=> s_drop) else $error("hinted bcast sent");
	a_err_pulse: assert property (err_out |=> !err_out) else $error("err too long");
	a_stall_hold: assert property (mo && !msg_ready_in && ce_in |=> mo &&
		$stable(msg_target_out)) else $error("message not held");
	a_ext_answer: assert property (s_take ##0 (irq_mode_in == `IDR_MODE_EXT_PHYS &&
		!c_q[6] && irq_target_in != 32'hFFFFFFFF) |=> ##1 mo && msg_target_out == t_q)
		else $error("physical message late or altered");
	a_hint_kept: assert property (mo && !m_q[1] && !(m_q == 2'h0 && c_q[6]) |->
		msg_hint_out == h_q) else $error("hint changed");
	a_leg_clear: assert property (mo && m_q == 2'h0 && c_q[6] |-> !msg_hint_out)
		else $error("hint kept on forced bcast");
	a_clus_onehot: assert property (mo && m_q == 2'h2 && !c_q[2] && h_q |->
		!msg_hint_out && $onehot(msg_target_out[7:0])) else $error("bad cluster pick");
	a_flat_logical: assert property (mo && m_q == 2'h3 |-> msg_logical_out)
		else $error("flat sent physical");
endmodule // idr_router_assertions
bind idr_router idr_router_assertions u_idr_router_assertions (.clk_in(clk_in),
	.rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .irq_valid_in(irq_valid_in), .irq_ready_out(irq_ready_out),
	.irq_mode_in(irq_mode_in), .irq_target_in(irq_target_in), .irq_hint_in(irq_hint_in),
	.msg_valid_out(msg_valid_out), .msg_ready_in(msg_ready_in),
	.msg_logical_out(msg_logical_out), .msg_target_out(msg_target_out),
	.msg_hint_out(msg_hint_out), .err_out(err_out));

// file: sim/idr_fabric_model.sv
// fabric side model: takes each message one cycle after it appears, or after a stall
`timescale 1ns/1ps
module idr_fabric_model (
	input  wire clk_in,
	input  wire rst_in,
	input  wire valid_in,
	input  wire slow_in,
	output reg  ready_out
);
	reg [1:0] wait_cnt;
	// a slow socket makes the router hold its fields across stalls
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_out <= 1'b0;
			wait_cnt  <= 2'h0;
		end else if (ready_out || !valid_in) begin
			ready_out <= 1'b0;
			wait_cnt  <= 2'h0;
		end else if (slow_in && wait_cnt != 2'h2) begin
			wait_cnt <= wait_cnt + 2'h1;
		end else begin
			ready_out <= 1'b1;
		end
	end
endmodule // idr_fabric_model

// file: sim/interrupt_delivery_router_test.sv
// self-checking bench for the interrupt delivery router
`timescale 1ns/1ps
`include "idr_map.vh"
module interrupt_delivery_router_test;
	reg         clk, rst, wr, rd, iv, ih, slow, ce;
	reg  [3:0]  a;
	reg  [31:0] wd, it;
	reg  [1:0]  im;
	reg  [7:0]  vc;
	wire [31:0] rdat, mt;
	wire [7:0]  mvc;
	wire [5:0]  mn;
	wire        ir, mv, mr, ml, mh, er;
	reg  [31:0] got_t [0:15];
	reg  [31:0] got_n [0:15];
	reg  [31:0] got_h [0:15];
	integer     got, errs, errors, n_tests, i;
	idr_router u_idr_router (.clk_in(clk), .rst_in(rst), .ce_in(ce), .reg_addr_in(a),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
		.irq_valid_in(iv), .irq_ready_out(ir), .irq_mode_in(im), .irq_target_in(it),
		.irq_vector_in(vc), .irq_hint_in(ih), .irq_redirect_in(1'b0), .msg_valid_out(mv),
		.msg_ready_in(mr), .msg_logical_out(ml), .msg_node_out(mn), .msg_target_out(mt),
		.msg_vector_out(mvc), .msg_hint_out(mh), .err_out(er));
	idr_fabric_model u_idr_fabric_model (.clk_in(clk), .rst_in(rst), .valid_in(mv),
		.slow_in(slow), .ready_out(mr));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (mv === 1'b1 && mr === 1'b1 && got < 16) begin
			got_t[got] = mt;
			got_n[got] = {26'h0, mn};
			got_h[got] = {22'h0, mvc, ml, mh};
			got = got + 1;
		end
		if (er === 1'b1)
			errs = errs + 1;
	end
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wreg(input [3:0] ad, input [31:0] d);
		begin
			@(posedge clk);
			a <= ad;
			wd <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [3:0] ad, input [31:0] e);
		begin
			@(posedge clk);
			a <= ad;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			@(negedge clk);
			chk(rdat, e);
		end
	endtask
	// one request, then collect the messages that it fans out to
	task send(input [1:0] m, input [31:0] t, input [7:0] v, input h, input integer n);
		integer k;
		begin
			@(negedge clk);
			got = 0;
			errs = 0;
			@(posedge clk);
			iv <= 1'b1;
			im <= m;
			it <= t;
			vc <= v;
			ih <= h;
			@(negedge clk);
			for (k = 0; k < 50 && ir !== 1'b1; k = k + 1)
				@(negedge clk);
			@(posedge clk);
			iv <= 1'b0;
			for (k = 0; k < 100 && got < n; k = k + 1)
				@(posedge clk);
			repeat (8) @(posedge clk);
			chk(got, n);
		end
	endtask
	task t_regs;
		begin
			wreg(4'h0, 32'h0000005D);
			rreg(4'h0, 32'h0000005D);
			rreg(4'hF, 32'h00000000);
			// a write while the clock enable is low must leave the register alone
			ce <= 1'b0;
			wreg(4'h0, 32'h00000011);
			ce <= 1'b1;
			rreg(4'h0, 32'h0000005D);
			wreg(4'h0, 32'h00000000);
			wreg(4'h1, 32'h00000005);
			wreg(4'h2, 32'h00000003);
			wreg(4'h3, 32'h00000011);
			wreg(4'h2, 32'h0000000F);
			wreg(4'h3, 32'h00000022);
			$display("registers done");
		end
	endtask
	task t_phys;
		begin
			send(`IDR_MODE_LEG_PHYS, 32'h00000003, 8'h00, 1'b1, 1);
			chk(got_n[0], 32'h11);
			chk(got_h[0], 32'h1);
			send(`IDR_MODE_EXT_PHYS, 32'h000000FF, 8'h00, 1'b0, 1);
			chk(got_n[0], 32'h22);
			slow <= 1'b1;
			send(`IDR_MODE_LEG_PHYS, 32'h000000FF, 8'h00, 1'b0, 2);
			chk(got_n[1], 32'h2);
			chk(got_h[1], 32'h0);
			send(`IDR_MODE_EXT_PHYS, 32'hFFFFFFFF, 8'h00, 1'b0, 2);
			slow <= 1'b0;
			send(`IDR_MODE_EXT_CLUS, 32'hFFFF0001, 8'h00, 1'b0, 2);
			send(`IDR_MODE_LEG_PHYS, 32'h000000FF, 8'h00, 1'b1, 0);
			chk(errs, 1);
			wreg(4'h0, 32'h00000040);
			send(`IDR_MODE_LEG_PHYS, 32'h00000003, 8'h00, 1'b1, 2);
			chk(got_h[1], 32'h0);
			send(`IDR_MODE_EXT_PHYS, 32'h00000003, 8'h00, 1'b1, 2);
			chk(got_h[0], 32'h1);
			wreg(4'h0, 32'h00000000);
			wreg(4'h4, 32'h002A001F);
			send(`IDR_MODE_LEG_PHYS, 32'h00000013, 8'h00, 1'b0, 1);
			chk(got_n[0], 32'h2A);
			wreg(4'h4, 32'h00000000);
			$display("physical done");
		end
	endtask
	task t_clus;
		begin
			wreg(4'h0, 32'h00000001);
			for (i = 0; i < 4; i = i + 1) begin
				send(`IDR_MODE_EXT_CLUS, 32'h00030016, 8'h00, 1'b1, 1);
				chk(got_t[0], i == 1 ? 32'h00030004 : i == 2 ? 32'h00030010 : 32'h00030002);
				chk(got_h[0], 32'h2);
				if (i == 0) begin
					send(`IDR_MODE_EXT_CLUS, 32'h00050016, 8'h00, 1'b1, 1);
					chk(got_t[0], 32'h00050002);
				end
			end
			wreg(4'h0, 32'h00000000);
			send(`IDR_MODE_EXT_CLUS, 32'h00030081, 8'h20, 1'b1, 1);
			chk(got_t[0], 32'h00030001);
			wreg(4'h0, 32'h00000004);
			send(`IDR_MODE_EXT_CLUS, 32'h00030016, 8'h00, 1'b1, 1);
			chk(got_t[0], 32'h00030016);
			chk(got_h[0], 32'h3);
			$display("cluster done");
		end
	endtask
	task t_flat;
		begin
			wreg(4'h0, 32'h00000000);
			send(`IDR_MODE_FLAT_LOG, 32'h00000081, 8'h20, 1'b1, 2);
			chk(got_t[1], 32'h00000001);
			// all-ones mask makes the pick equal the start field itself
			for (i = 0; i < 4; i = i + 1) begin
				wreg(4'h0, {27'h0, i[1:0], 3'h0});
				send(`IDR_MODE_FLAT_LOG, 32'h000000FF, 8'h5A, 1'b1, 2);
				chk(got_t[0], i == 1 ? 32'h08 : i == 3 ? 32'h04 : 32'h20);
				chk(got_h[0], 32'h0000016A);
			end
			send(`IDR_MODE_FLAT_LOG, 32'h00000000, 8'h20, 1'b1, 0);
			chk(errs, 1);
			rreg(4'h6, 32'h00000002);
			$display("flat done");
		end
	endtask
	task conclude;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, errors);
			if (errors == 0 && n_tests > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		errors = errors + 1;
		conclude;
	end
	initial begin
		{rst, wr, rd, iv, ih, slow} = 6'h20;
		ce = 1'b1;
		{a, wd, it, im, vc} = 78'h0;
		{got, errs, errors, n_tests} = 128'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_phys;
		t_clus;
		t_flat;
		conclude;
	end
endmodule // interrupt_delivery_router_test
